// file: sim/nod_properties.sv
`include "nod_consts.svh"
`default_nettype none

// ----------------------------------------
// link watcher between controller and device
// ----------------------------------------
module nod_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] idx,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic irq_en,
  input wire logic flag,
  input wire logic en,
  input wire logic out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic clr;
  logic wctl;
  assign clr = wr && idx == `NOD_IDX_FLAG && !wdata[`NOD_FLAG_BIT];
  assign wctl = wr && idx == `NOD_IDX_CTRL;

  chk_flag_sticky: assert property (flag && !clr |=> flag)
    else $error("flag dropped without clear");
  chk_flag_cause: assert property ($rose(flag) |-> $past(en) || $past(irq_en) || $past(wr))
    else $error("flag rose without cause");
  chk_reset_quiet: assert property (!$past(presetn) |-> !flag && !en && !out)
    else $error("outputs not clear after reset");
  chk_en_write: assert property (wctl |=> en == $past(wdata[`NOD_CTRL_EN]))
    else $error("enable not written");
  chk_en_hold: assert property (!wctl |=> $stable(en))
    else $error("enable changed without write");
  chk_pol_irq: assert property (irq_en && !en && $changed(out) |-> ##[0:3] flag)
    else $error("polarity change not flagged");
  chk_top_zero: assert property (rd && idx inside {`NOD_IDX_ACCU, `NOD_IDX_INCU}
    |=> rdata[7:4] == 4'h0) else $error("upper nibble not zero");
  chk_clk_rsv: assert property (rd && idx == `NOD_IDX_CLK |=> !rdata[4])
    else $error("clock config bit 4 not zero");
  chk_ctl_status: assert property (rd && idx == `NOD_IDX_CTRL
    |=> rdata[5] == $past(out) && rdata[7] == $past(en) && rdata[6] == 1'h0)
    else $error("control read does not show output");

  cov_flag: cover property ($rose(flag));
  cov_out: cover property (en && $changed(out));
  cov_pol: cover property (irq_en && !en && $changed(out));
endmodule

`default_nettype wire

// file: sim/numeric_osc_divider_tb_top.sv
`include "nod_consts.svh"
`default_nettype none

// ----------------------------------------
// bench top: apb driver, source clocks, reference model
// ----------------------------------------
module numeric_osc_divider_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] FAST = 4'h2;
  logic pclk;
  logic presetn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic periph_nco_in;
  logic [7:0] src;
  logic fast_osc_clk;
  logic fast_osc_keep_on;
  logic nco_out;
  logic [31:0] rv;
  logic err;
  int bad_count;
  int num_checks;

  nod_if link_if ();
  nod_device #(.FAST_OSC_CODE(FAST)) nod_device_inst (.pclk(pclk), .presetn(presetn),
    .link(link_if.dev), .src_clk(src), .fast_osc_clk(fast_osc_clk),
    .fast_osc_keep_on(fast_osc_keep_on), .nco_out(nco_out));
  nod_host nod_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link_if.host), .irq(irq), .periph_nco_in(periph_nco_in));
  nod_properties nod_properties_inst (.pclk(pclk), .presetn(presetn), .idx(link_if.idx),
    .wr(link_if.wr), .rd(link_if.rd), .wdata(link_if.wdata), .rdata(link_if.rdata),
    .irq_en(link_if.irq_en), .flag(link_if.flag), .en(link_if.en), .out(link_if.out));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic limit(input int n, input int m);
    if (n >= m) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'h1;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    limit(n, 20);
    rv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // one device access through the controller, waiting out busy
  task automatic dev(input logic [3:0] i, input logic w, input logic [7:0] d);
    int n;
    apb(`NOD_APB_ADDR, 1'h1, {28'h0, i});
    apb(`NOD_APB_WDATA, 1'h1, {24'h0, d});
    apb(`NOD_APB_CMD, 1'h1, {30'h0, !w, w});
    n = 0;
    do begin
      apb(`NOD_APB_STATUS, 1'h0, 32'h0);
      n++;
    end while (rv[`NOD_ST_BUSY] !== 1'h0 && n < 10);
    limit(n, 10);
    apb(`NOD_APB_RDATA, 1'h0, 32'h0);
  endtask

  task automatic rdc(input logic [3:0] i, input logic [7:0] e);
    dev(i, 1'h0, 8'h00);
    check(rv, {24'h0, e});
  endtask

  // upper and high bytes first, low byte last
  task automatic w20(input logic [3:0] lo, input logic [19:0] v);
    dev(lo + 4'h2, 1'h1, {4'($urandom), v[19:16]});
    dev(lo + 4'h1, 1'h1, v[15:8]);
    dev(lo, 1'h1, v[7:0]);
  endtask

  task automatic r20(input logic [3:0] lo, input logic [19:0] e);
    rdc(lo, e[7:0]);
    rdc(lo + 4'h1, e[15:8]);
    rdc(lo + 4'h2, {4'h0, e[19:16]});
  endtask

  task automatic ticks(input int n, input int c);
    repeat (n) begin
      src[c - 3] <= 1'h1;
      repeat (4) @(posedge pclk);
      src[c - 3] <= 1'h0;
      repeat (4) @(posedge pclk);
    end
  endtask

  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    int acc;
    int inc;
    int n;
    int cy;
    int cnt;
    logic mode;
    logic output_invert;
    logic [2:0] pws;
    bad_count = 0;
    num_checks = 0;
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    src = 8'h00;
    fast_osc_clk = 1'h0;
    void'($urandom(32'hDC5CE243));
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      rdc(4'(i), 8'h00);
    end
    apb(12'h020, 1'h1, 32'h0);
    check({31'h0, err}, 32'h1);
    // ----------------------------------------
    // fixed duty over every source pin code (3 to 10)
    // ----------------------------------------
    acc = 0;
    mode = 1'h0;
    for (int c = 3; c <= 10; c++) begin
      inc = $urandom_range(32'hFFFFF, 1);
      n = $urandom_range(12, 1);
      pws = 3'($urandom);
      dev(`NOD_IDX_FLAG, 1'h1, 8'h00);
      w20(`NOD_IDX_INCL, inc[19:0]);
      dev(`NOD_IDX_CLK, 1'h1, {pws, 1'h1, 4'(c)});
      rdc(`NOD_IDX_CLK, {pws, 1'h0, 4'(c)});
      dev(`NOD_IDX_CTRL, 1'h1, 8'h80);
      ticks(n, c);
      dev(`NOD_IDX_CTRL, 1'h1, 8'h00);
      cy = 0;
      repeat (n) begin
        acc += inc;
        if (acc >= 32'h100000) begin
          acc -= 32'h100000;
          cy++;
          mode = ~mode;
        end
      end
      r20(`NOD_IDX_ACCL, acc[19:0]);
      check({30'h0, nco_out, periph_nco_in}, {30'h0, mode, mode});
      apb(`NOD_APB_STATUS, 1'h0, 32'h0);
      check({30'h0, rv[`NOD_ST_OUT], rv[`NOD_ST_FLAG]}, {30'h0, mode, cy > 0});
    end
    // ----------------------------------------
    // pulse mode over every width code
    // ----------------------------------------
    for (int p = 0; p < 8; p++) begin
      output_invert = 1'($urandom);
      w20(`NOD_IDX_INCL, 20'h00800);
      w20(`NOD_IDX_ACCL, 20'hFF800);
      dev(`NOD_IDX_CLK, 1'h1, {3'(p), 5'h03});
      dev(`NOD_IDX_CTRL, 1'h1, {3'h4, output_invert, 4'h1});
      cnt = 0;
      repeat ((1 << p) + 2) begin
        ticks(1, 3);
        cnt += (nco_out !== output_invert);
      end
      dev(`NOD_IDX_CTRL, 1'h1, {3'h0, output_invert, 4'h1});
      check(cnt, 1 << p);
    end
    // ----------------------------------------
    // polarity event, interrupt gating, clear
    // ----------------------------------------
    dev(`NOD_IDX_CTRL, 1'h1, 8'h00);
    apb(`NOD_APB_IRQEN, 1'h1, 32'h3);
    dev(`NOD_IDX_FLAG, 1'h1, 8'h00);
    dev(`NOD_IDX_CTRL, 1'h1, 8'h10);
    apb(`NOD_APB_STATUS, 1'h0, 32'h0);
    check({28'h0, rv[3:0]}, 32'h6);
    check({31'h0, irq}, 32'h0);
    dev(`NOD_IDX_FLAG, 1'h1, 8'h00);
    apb(`NOD_APB_STATUS, 1'h0, 32'h0);
    check({31'h0, rv[`NOD_ST_FLAG]}, 32'h0);
    w20(`NOD_IDX_INCL, 20'h80000);
    dev(`NOD_IDX_CTRL, 1'h1, 8'h90);
    ticks(2, 3);
    repeat (4) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    // step written while running: old step used until a falling source edge
    dev(`NOD_IDX_CTRL, 1'h1, 8'h10);
    w20(`NOD_IDX_ACCL, 20'h00000);
    dev(`NOD_IDX_CTRL, 1'h1, 8'h90);
    inc = $urandom_range(32'h7FFFF, 1);
    w20(`NOD_IDX_INCL, inc[19:0]);
    ticks(2, 3);
    r20(`NOD_IDX_ACCL, 20'h80000 + inc[19:0]);
    apb(`NOD_APB_IRQEN, 1'h1, 32'h1);
    apb(`NOD_APB_STATUS, 1'h0, 32'h0);
    check({30'h0, irq, rv[`NOD_ST_FLAG]}, 32'h1);
    dev(`NOD_IDX_FLAG, 1'h1, 8'h00);
    apb(`NOD_APB_STATUS, 1'h0, 32'h0);
    check({31'h0, rv[`NOD_ST_FLAG]}, 32'h0);
    dev(`NOD_IDX_CLK, 1'h1, {4'h0, FAST});
    check({31'h0, fast_osc_keep_on}, 32'h1);
    dev(`NOD_IDX_CLK, 1'h1, 8'h03);
    check({31'h0, fast_osc_keep_on}, 32'h0);
    report_and_stop();
  end
endmodule

`default_nettype wire

// file: src/nod_consts.svh
`ifndef NOD_CONSTS_SVH
`define NOD_CONSTS_SVH

// --------------------------------------------------------------------------
// device register indices on the link
// --------------------------------------------------------------------------
`define NOD_IDX_CTRL 4'h0
`define NOD_IDX_CLK 4'h1
`define NOD_IDX_ACCL 4'h2
`define NOD_IDX_ACCH 4'h3
`define NOD_IDX_ACCU 4'h4
`define NOD_IDX_INCL 4'h5
`define NOD_IDX_INCH 4'h6
`define NOD_IDX_INCU 4'h7
`define NOD_IDX_FLAG 4'h8

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define NOD_CTRL_EN 7
`define NOD_CTRL_OUT 5
`define NOD_CTRL_POL 4
`define NOD_CTRL_PFM 0
`define NOD_CLK_PWS_HI 7
`define NOD_CLK_PWS_LO 5
`define NOD_CLK_CKS_HI 3
`define NOD_CLK_CKS_LO 0
`define NOD_FLAG_BIT 0

// --------------------------------------------------------------------------
// source codes and pulse width
// --------------------------------------------------------------------------
`define NOD_CKS_FIRST 4'h3
`define NOD_CKS_LAST 4'hA
`define NOD_PW_MAX_CNT 8'h7F
`define NOD_PWS_MAX 3'h7

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define NOD_RST_BYTE 8'h00
`define NOD_RST_WORD 20'h00000

// --------------------------------------------------------------------------
// controller apb map
// --------------------------------------------------------------------------
`define NOD_APB_ADDR 12'h000
`define NOD_APB_WDATA 12'h004
`define NOD_APB_CMD 12'h008
`define NOD_APB_STATUS 12'h00C
`define NOD_APB_RDATA 12'h010
`define NOD_APB_IRQEN 12'h014
`define NOD_CMD_WR 0
`define NOD_CMD_RD 1
`define NOD_ST_BUSY 0
`define NOD_ST_FLAG 1
`define NOD_ST_OUT 2
`define NOD_ST_EN 3
`define NOD_IE_OVF 0
`define NOD_IE_GLOBAL 1

`endif

// file: src/nod_device.sv
// Contract
// - polarity bit inverts final output
// - polarity change with irq enabled flags event
// - every carry sets overflow flag
// - software sets enable, irq enable, global
// - flag stays set until software clears
// - reset clears all registers to zero
// - runs from selected source clock only
// - fast oscillator kept on when selected and enabled
// - width code gives 1 to 128 clocks
// - width used only in pulse mode
// - software keeps width below overflow period
// - four-bit source select, high codes reserved
// - accumulator upper nibble top reads zero
// - accumulator bytes change live, not atomic
// - software avoids accumulator writes while running
// - step shadow loads on falling source edge
// - step is upper nibble, high, low
// - final output routed to peripherals
// - fixed duty mode toggles on carry
// - pulse starts at carry, lasts width
// - pulse mode bit selects pulse mode
// - accumulator adds shadow each rising edge
`include "nod_consts.svh"
`default_nettype none

module nod_device #(
  parameter logic [3:0] FAST_OSC_CODE = 4'h2
) (
  input wire logic pclk,
  input wire logic presetn,
  nod_if.dev link,
  input wire logic [7:0] src_clk,
  input wire logic fast_osc_clk,
  output logic fast_osc_keep_on,
  output logic nco_out
);

  // --------------------------------------------------------------------------
  // source clock selection and edge detection
  // --------------------------------------------------------------------------
  nod_pkg::nod_dev_state_t q;
  nod_pkg::nod_dev_state_t d;
  logic [3:0] src_off;
  logic [7:0] pin_rise;
  logic [7:0] pin_fall;
  logic fast_rise;
  logic fast_fall;
  logic src_rise;
  logic src_fall;

  assign src_off = q.cks - `NOD_CKS_FIRST;

  // every pin is synchronised before the select: no raw pin reaches logic,
  // and a change of source cannot show a false edge
  for (genvar g = 0; g < 8; g++) begin : g_src_sync
    nod_edge_sync u_src (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(src_clk[g]),
      .rise(pin_rise[g]),
      .fall(pin_fall[g])
    );
  end

  nod_edge_sync u_fast (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(fast_osc_clk),
    .rise(fast_rise),
    .fall(fast_fall)
  );

  always_comb begin
    src_rise = 1'b0;
    src_fall = 1'b0;
    if (q.cks >= `NOD_CKS_FIRST && q.cks <= `NOD_CKS_LAST) begin
      src_rise = pin_rise[src_off[2:0]];
      src_fall = pin_fall[src_off[2:0]];
    end else if (q.cks == FAST_OSC_CODE) begin
      src_rise = fast_rise;
      src_fall = fast_fall;
    end
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  logic [20:0] sum;
  logic carry;
  logic tick;

  always_comb begin
    d = q;
    tick = q.en & src_rise;
    sum = {1'b0, q.acc} + {1'b0, q.shadow};
    carry = 1'b0;

    // step shadow: follows the step value while disabled
    if (!q.en) begin
      d.shadow = q.inc;
      d.load_pend = 1'b0;
    end else if (q.load_pend && src_fall) begin
      d.shadow = q.inc;
      d.load_pend = 1'b0;
    end

    // accumulate on the selected source's rising edge only
    if (tick) begin
      d.acc = sum[19:0];
      carry = sum[20];
    end

    // output mode stage
    if (carry) begin
      if (q.pulse_mode_select) begin
        d.mode_out = 1'b1;
        d.pw_cnt = `NOD_PW_MAX_CNT >> (`NOD_PWS_MAX - q.pws);
      end else begin
        d.mode_out = ~q.mode_out;
      end
    end else if (tick && q.pulse_mode_select && q.mode_out) begin
      if (q.pw_cnt != 8'h00) begin
        d.pw_cnt = q.pw_cnt - 8'h01;
      end else begin
        d.mode_out = 1'b0;
      end
    end

    // register writes
    if (link.wr) begin
      case (link.idx)
        `NOD_IDX_CTRL: begin
          d.en = link.wdata[`NOD_CTRL_EN];
          d.output_invert = link.wdata[`NOD_CTRL_POL];
          d.pulse_mode_select = link.wdata[`NOD_CTRL_PFM];
        end
        `NOD_IDX_CLK: begin
          d.pws = link.wdata[`NOD_CLK_PWS_HI:`NOD_CLK_PWS_LO];
          d.cks = link.wdata[`NOD_CLK_CKS_HI:`NOD_CLK_CKS_LO];
        end
        `NOD_IDX_ACCL: begin
          d.acc[7:0] = link.wdata;
        end
        `NOD_IDX_ACCH: begin
          d.acc[15:8] = link.wdata;
        end
        `NOD_IDX_ACCU: begin
          d.acc[19:16] = link.wdata[3:0];
        end
        `NOD_IDX_INCL: begin
          d.inc[7:0] = link.wdata;
          d.load_pend = q.en;
        end
        `NOD_IDX_INCH: begin
          d.inc[15:8] = link.wdata;
        end
        `NOD_IDX_INCU: begin
          d.inc[19:16] = link.wdata[3:0];
        end
        `NOD_IDX_FLAG: begin
          if (!link.wdata[`NOD_FLAG_BIT]) begin
            d.flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // polarity stage, final output
    d.out = d.mode_out ^ d.output_invert;

    // flag sets after the clear so an event in the clear cycle survives
    if (carry) begin
      d.flag = 1'b1;
    end
    if (link.irq_en && (d.output_invert != q.output_invert) && (d.out != q.out)) begin
      d.flag = 1'b1;
    end

    d.keep_on = d.en && (d.cks == FAST_OSC_CODE);

    // register reads, answered at the next edge
    if (link.rd) begin
      case (link.idx)
        `NOD_IDX_CTRL: d.rdata = {q.en, 1'b0, q.out, q.output_invert, 3'h0, q.pulse_mode_select};
        `NOD_IDX_CLK: d.rdata = {q.pws, 1'b0, q.cks};
        `NOD_IDX_ACCL: d.rdata = q.acc[7:0];
        `NOD_IDX_ACCH: d.rdata = q.acc[15:8];
        `NOD_IDX_ACCU: d.rdata = {4'h0, q.acc[19:16]};
        `NOD_IDX_INCL: d.rdata = q.inc[7:0];
        `NOD_IDX_INCH: d.rdata = q.inc[15:8];
        `NOD_IDX_INCU: d.rdata = {4'h0, q.inc[19:16]};
        `NOD_IDX_FLAG: d.rdata = {7'h00, q.flag};
        default: d.rdata = `NOD_RST_BYTE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.en <= 1'b0;
      q.output_invert <= 1'b0;
      q.pulse_mode_select <= 1'b0;
      q.pws <= 3'h0;
      q.cks <= 4'h0;
      q.acc <= `NOD_RST_WORD;
      q.inc <= `NOD_RST_WORD;
      q.shadow <= `NOD_RST_WORD;
      q.load_pend <= 1'b0;
      q.mode_out <= 1'b0;
      q.pw_cnt <= 8'h00;
      q.out <= 1'b0;
      q.flag <= 1'b0;
      q.rdata <= `NOD_RST_BYTE;
      q.keep_on <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign nco_out = q.out;
  assign fast_osc_keep_on = q.keep_on;
  assign link.rdata = q.rdata;
  assign link.flag = q.flag;
  assign link.en = q.en;
  assign link.out = q.out;

endmodule

`default_nettype wire

// file: src/nod_edge_sync.sv
`default_nettype none

// two-stage synchroniser plus one stage for edge detection
module nod_edge_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic rise,
  output logic fall
);
  logic [2:0] sh_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 3'h0;
    end else begin
      sh_q <= {sh_q[1:0], async_in};
    end
  end

  assign rise = sh_q[1] & ~sh_q[2];
  assign fall = ~sh_q[1] & sh_q[2];
endmodule

`default_nettype wire

// file: src/nod_host.sv
`include "nod_consts.svh"
`default_nettype none

// controller: apb registers turned into single-cycle link accesses
module nod_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  nod_if.host link,
  output logic irq,
  output logic periph_nco_in
);
  nod_pkg::nod_host_state_t q;
  nod_pkg::nod_host_state_t d;
  logic access;
  logic busy;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    d = q;
    busy = q.st != nod_pkg::NOD_IDLE;
    access = psel && penable && !q.pready;
    d.pready = access;
    d.pslverr = 1'b0;
    d.prdata = 32'h00000000;
    d.wr = 1'b0;
    d.rd = 1'b0;

    case (q.st)
      nod_pkg::NOD_IDLE: begin
      end
      nod_pkg::NOD_STROBE: begin
        d.st = nod_pkg::NOD_CAPT;
      end
      nod_pkg::NOD_CAPT: begin
        d.rdata = link.rdata;
        d.st = nod_pkg::NOD_IDLE;
      end
      default: begin
        d.st = nod_pkg::NOD_IDLE;
      end
    endcase

    if (access) begin
      case (paddr)
        `NOD_APB_ADDR: begin
          if (pwrite) begin
            d.idx = pwdata[3:0];
          end
          d.prdata = {28'h0000000, q.idx};
        end
        `NOD_APB_WDATA: begin
          if (pwrite) begin
            d.wdata = pwdata[7:0];
          end
          d.prdata = {24'h000000, q.wdata};
        end
        `NOD_APB_CMD: begin
          if (pwrite && !busy && (pwdata[`NOD_CMD_WR] || pwdata[`NOD_CMD_RD])) begin
            d.wr = pwdata[`NOD_CMD_WR];
            d.rd = ~pwdata[`NOD_CMD_WR];
            d.st = nod_pkg::NOD_STROBE;
          end
        end
        `NOD_APB_STATUS: begin
          d.prdata[`NOD_ST_BUSY] = busy;
          d.prdata[`NOD_ST_FLAG] = link.flag;
          d.prdata[`NOD_ST_OUT] = link.out;
          d.prdata[`NOD_ST_EN] = link.en;
        end
        `NOD_APB_RDATA: begin
          d.prdata = {24'h000000, q.rdata};
        end
        `NOD_APB_IRQEN: begin
          if (pwrite) begin
            d.ie = pwdata[`NOD_IE_OVF];
            d.gie = pwdata[`NOD_IE_GLOBAL];
          end
          d.prdata = {30'h0, q.gie, q.ie};
        end
        default: begin
          d.pslverr = 1'b1;
        end
      endcase
    end

    // interrupt needs enable, overflow enable and global enable
    d.irq = link.flag && link.en && q.ie && q.gie;
    d.periph = link.out;
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.st <= nod_pkg::NOD_IDLE;
      q.idx <= 4'h0;
      q.wdata <= 8'h00;
      q.rdata <= 8'h00;
      q.go_wr <= 1'b0;
      q.ie <= 1'b0;
      q.gie <= 1'b0;
      q.wr <= 1'b0;
      q.rd <= 1'b0;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
      q.prdata <= 32'h00000000;
      q.irq <= 1'b0;
      q.periph <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
  assign periph_nco_in = q.periph;
  assign link.idx = q.idx;
  assign link.wdata = q.wdata;
  assign link.wr = q.wr;
  assign link.rd = q.rd;
  assign link.irq_en = q.ie & q.gie;

endmodule

`default_nettype wire

// file: src/nod_if.sv
`default_nettype none

interface nod_if;
  logic [3:0] idx;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic irq_en;
  logic flag;
  logic en;
  logic out;

  modport dev (
    input idx,
    input wr,
    input rd,
    input wdata,
    input irq_en,
    output rdata,
    output flag,
    output en,
    output out
  );

  modport host (
    output idx,
    output wr,
    output rd,
    output wdata,
    output irq_en,
    input rdata,
    input flag,
    input en,
    input out
  );
endinterface

`default_nettype wire

// file: src/nod_pkg.sv
`default_nettype none

package nod_pkg;

  typedef enum logic [2:0] {
    NOD_IDLE = 3'h1,
    NOD_STROBE = 3'h2,
    NOD_CAPT = 3'h4
  } nod_host_st_t;

  typedef struct packed {
    logic en;
    logic output_invert;
    logic pulse_mode_select;
    logic [2:0] pws;
    logic [3:0] cks;
    logic [19:0] acc;
    logic [19:0] inc;
    logic [19:0] shadow;
    logic load_pend;
    logic mode_out;
    logic [7:0] pw_cnt;
    logic out;
    logic flag;
    logic [7:0] rdata;
    logic keep_on;
  } nod_dev_state_t;

  typedef struct packed {
    nod_host_st_t st;
    logic [3:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic go_wr;
    logic ie;
    logic gie;
    logic wr;
    logic rd;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic periph;
  } nod_host_state_t;

endpackage

`default_nettype wire
